// ---- rtl/cdio_datapath.sv ----
// Notes on behaviour
// - Function field goes to every slice each micro-cycle.
// - Slice address outputs drive the upper system address byte.
// - Constant select low: constant bus carries inverted mask bits.
// - Constant select high: all ones if polarity low, all zeros if high.
// - Input bus gets a source only with constant select high and pattern match.
// - Mask bits M3..M7 pick data or clock shift register outputs.
// - Error or status lines may be routed onto input bits 4..7.
// - Patterns M7..M3: data 10000, clock 10010, error 11010, status 11101.
// - Address outputs enabled only while bus granted; data outputs always.
// - Carry and shift chain between slices; combined line feeds sequencer flag.
// - Flag output feeds lowest carry-in; inverted combined line is branch bit.
// - Read data strobe shifts bits through two cascaded nibbles into a byte.
// - Two lowest data register stages are exported.
// - Registers load only when empty and write gate true.
// - Slice data D0..D3 load first nibble, D4..D7 second.
// - Serial write data comes from last stage of second nibble.
// - Clock-bit strobe shifts clock registers, read out as a byte.
// - Clock load pattern from the two mark levels, other stages zero.
// - Opcode pulse latches inverted D0..D5 into sequencer, mode and unit select.
// - Address pulse latches low address byte, driven while bus granted.
// - High data byte driven when granted, memory write and wide mode.
// - Low data byte driven during memory write or result read.
// - Input latches take bus data on input strobe or memory data strobe.
// - Only one input latch drives the slice memory-data inputs.
// - Byte-lane level is a microprogram-held level.
`include "cdio_params.svh"
`default_nettype none
module cdio_datapath
   import cdio_pkg::*;
#(
   parameter int SLICES = `CDIO_SLICES
) (
   // Slice clock domain
   input wire logic clock_i,
   input wire logic nrst_i,
   // Link clock domain
   input wire logic link_clk_i,
   // Microword fields
   input wire logic [`CDIO_FW-1:0] slice_function_field_i,
   input wire logic [`CDIO_DW-1:0] microword_mask_field_i,
   input wire logic const_force_sel_i,
   input wire logic const_polarity_sel_i,
   input wire logic write_gate_level_i,
   input wire logic mark_pattern_a_i,
   input wire logic mark_pattern_b_i,
   input wire logic opcode_latch_pulse_i,
   input wire logic addr_latch_pulse_i,
   input wire logic low_byte_out_strobe_i,
   input wire logic high_byte_out_strobe_i,
   input wire logic bus_input_strobe_i,
   input wire logic byte_lane_level_i,
   input wire logic memory_write_i,
   input wire logic result_read_i,
   // Slice array outputs
   input wire logic [`CDIO_DW-1:0] slice_addr_i,
   input wire logic [`CDIO_DW-1:0] slice_data_i,
   input wire logic [SLICES-1:0] slice_carry_out_i,
   input wire logic [SLICES-1:0] slice_shift_out_i,
   input wire logic sequencer_flag_output_i,
   // Interface board pins, slice side
   input wire logic bus_granted_i,
   input wire logic memory_data_strobe_i,
   input wire logic [2*`CDIO_DW-1:0] sys_data_i,
   input wire logic overrun_error_i,
   input wire logic write_protect_flag_i,
   input wire logic write_fault_flag_i,
   input wire logic selected_drive_not_ready_i,
   input wire logic drive_ready_a_i,
   input wire logic drive_ready_b_i,
   input wire logic stop_flag_i,
   input wire logic track_zero_i,
   // Interface board serial pins, link side
   input wire logic serial_read_data_in_n_i,
   input wire logic read_data_strobe_n_i,
   input wire logic serial_read_clockbit_in_n_i,
   input wire logic clockbit_strobe_i,
   // Slice array drive
   output logic [`CDIO_FW-1:0] slice_function_field_o,
   output logic [`CDIO_DW-1:0] const_bus_o,
   output logic [`CDIO_DW-1:0] ibus_o,
   output logic [`CDIO_DW-1:0] mem_data_o,
   output logic address_output_enable_o,
   output logic data_output_enable_o,
   output logic [SLICES-1:0] slice_carry_in_o,
   output logic [SLICES-1:0] slice_shift_in_o,
   output logic sequencer_flag_input_o,
   output logic branch_addr_ctl_lsb_o,
   // Opcode latch
   output logic [2:0] seq_instr_sel_o,
   output logic wide_mode_o,
   output logic unit_select_lo_o,
   output logic unit_select_hi_o,
   // System bus drive
   output logic [`CDIO_DW-1:0] sys_addr_hi_o,
   output logic [`CDIO_DW-1:0] sys_addr_lo_o,
   output logic sys_addr_oe_o,
   output logic [`CDIO_DW-1:0] sys_data_lo_o,
   output logic sys_data_lo_oe_o,
   output logic [`CDIO_DW-1:0] sys_data_hi_o,
   output logic sys_data_hi_oe_o,
   // Serial write side
   output logic parallel_load_n_o,
   output logic serial_write_data_out_o,
   output logic data_reg_bit_a_out_o,
   output logic data_reg_bit_b_out_o
);

   if (SLICES * `CDIO_SLICE_W != `CDIO_DW) begin : g_chk
      $error("SLICES must cover exactly the 8-bit datapath");
   end

   // Pin synchronisers: first stage feeds only the second
   localparam int NSYNC = 2 * `CDIO_DW + 10;
   logic [NSYNC-1:0] pin_raw, pin_s1_r, pin_s2_r;
   assign pin_raw = {sys_data_i, selected_drive_not_ready_i, write_fault_flag_i,
                     write_protect_flag_i, overrun_error_i, track_zero_i, stop_flag_i,
                     drive_ready_b_i, drive_ready_a_i, bus_granted_i, memory_data_strobe_i};
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
      end
   end
   wire [2*`CDIO_DW-1:0] sys_data_s = pin_s2_r[NSYNC-1:10];
   wire [3:0] err_s = pin_s2_r[9:6];
   wire [3:0] stat_s = pin_s2_r[5:2];
   wire granted_s = pin_s2_r[1];
   wire memstb_s = pin_s2_r[0];

   // Link domain state
   logic [`CDIO_DW-1:0] dsr_r, csr_r, rx_dat_r, rx_clk_r;
   logic [3:0] cnt_r;
   logic rx_tgl_r, empty_r, req_l1_r, req_l2_r, req_l3_r;
   // Slice domain state
   logic [`CDIO_DW-1:0] rdata_r, rclk_r, tx_dat_r, in_lo_r, in_hi_r;
   logic tx_ab_r, tx_b_r, req_tgl_r, pending_r, memstb_d_r;
   logic rx_s1_r, rx_s2_r, rx_s3_r, emp_s1_r, emp_s2_r;

   // Constant bus: mask inverted, or a forced uniform value
   wire [`CDIO_DW-1:0] const_nxt = !const_force_sel_i ? ~microword_mask_field_i :
                                   (const_polarity_sel_i ? `CDIO_ZERO : `CDIO_ONES);

   // Input-bus source decode from M7..M3, only with constant select high
   wire [4:0] msel = microword_mask_field_i[`CDIO_DW-1:3];
   cdio_isrc_t isrc;
   assign isrc = !const_force_sel_i ? CDIO_SRC_NONE :
                 (msel == `CDIO_PAT_DATA) ? CDIO_SRC_DATA :
                 (msel == `CDIO_PAT_CLK) ? CDIO_SRC_CLK :
                 (msel == `CDIO_PAT_ERR) ? CDIO_SRC_ERR :
                 (msel == `CDIO_PAT_STAT) ? CDIO_SRC_STAT : CDIO_SRC_NONE;
   logic [`CDIO_DW-1:0] ibus_nxt;
   always_comb begin
      case (isrc)
         CDIO_SRC_DATA: ibus_nxt = rdata_r;
         CDIO_SRC_CLK: ibus_nxt = rclk_r;
         CDIO_SRC_ERR: ibus_nxt = {err_s, `CDIO_NIB_ZERO};
         CDIO_SRC_STAT: ibus_nxt = {stat_s, `CDIO_NIB_ZERO};
         default: ibus_nxt = `CDIO_ZERO;
      endcase
   end

   // Carry and shift chain; kept combinational so the ALU ripples in one cycle
   wire combined_co = slice_carry_out_i[SLICES-1] | slice_shift_out_i[0];
   assign slice_carry_in_o[0] = sequencer_flag_output_i;
   assign slice_shift_in_o[SLICES-1] = slice_carry_out_i[SLICES-1];
   for (genvar k = 1; k < SLICES; k++) begin : g_chain
      assign slice_carry_in_o[k] = slice_carry_out_i[k-1];
      assign slice_shift_in_o[k-1] = slice_shift_out_i[k];
   end
   assign sequencer_flag_input_o = combined_co;
   assign branch_addr_ctl_lsb_o = ~combined_co;

   // Memory strobe edge and byte-lane choice
   wire memstb_rise = memstb_s & ~memstb_d_r;
   wire in_cap = bus_input_strobe_i | memstb_rise;
   wire [`CDIO_DW-1:0] mem_nxt = byte_lane_level_i ? in_lo_r : in_hi_r;

   // Write load: the link is empty, write gate is up, nothing outstanding
   wire load_go = emp_s2_r & write_gate_level_i & ~pending_r;
   wire rx_new = rx_s2_r ^ rx_s3_r;

   // Slice-side microword and steering registers
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         slice_function_field_o <= '0;
         const_bus_o <= `CDIO_ONES;
         ibus_o <= `CDIO_ZERO;
         mem_data_o <= `CDIO_ZERO;
         sys_addr_hi_o <= `CDIO_ZERO;
         address_output_enable_o <= 1'b0;
         data_output_enable_o <= 1'b1;
         memstb_d_r <= 1'b0;
      end else begin
         slice_function_field_o <= slice_function_field_i;
         const_bus_o <= const_nxt;
         ibus_o <= ibus_nxt;
         mem_data_o <= mem_nxt;
         sys_addr_hi_o <= slice_addr_i;
         address_output_enable_o <= granted_s;
         data_output_enable_o <= 1'b1;
         memstb_d_r <= memstb_s;
      end
   end

   // Opcode, address and data latches with their bus enables
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {unit_select_hi_o, unit_select_lo_o, wide_mode_o, seq_instr_sel_o} <= '0;
         sys_addr_lo_o <= `CDIO_ZERO;
         sys_data_lo_o <= `CDIO_ZERO;
         sys_data_hi_o <= `CDIO_ZERO;
         sys_addr_oe_o <= 1'b0;
         sys_data_lo_oe_o <= 1'b0;
         sys_data_hi_oe_o <= 1'b0;
         in_lo_r <= `CDIO_ZERO;
         in_hi_r <= `CDIO_ZERO;
      end else begin
         if (opcode_latch_pulse_i) begin
            {unit_select_hi_o, unit_select_lo_o, wide_mode_o, seq_instr_sel_o} <=
               ~slice_data_i[`CDIO_OP_W-1:0];
         end
         if (addr_latch_pulse_i) sys_addr_lo_o <= slice_data_i;
         if (low_byte_out_strobe_i) sys_data_lo_o <= slice_data_i;
         if (high_byte_out_strobe_i) sys_data_hi_o <= slice_data_i;
         sys_addr_oe_o <= granted_s;
         sys_data_hi_oe_o <= granted_s & memory_write_i & wide_mode_o;
         sys_data_lo_oe_o <= memory_write_i | result_read_i;
         if (in_cap) begin
            in_lo_r <= sys_data_s[`CDIO_DW-1:0];
            in_hi_r <= sys_data_s[2*`CDIO_DW-1:`CDIO_DW];
         end
      end
   end

   // Slice side of the crossings: load request toggle, byte capture
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {rx_s1_r, rx_s2_r, rx_s3_r, emp_s1_r, emp_s2_r} <= '0;
         {req_tgl_r, pending_r, tx_ab_r, tx_b_r} <= '0;
         parallel_load_n_o <= 1'b1;
         tx_dat_r <= `CDIO_ZERO;
         rdata_r <= `CDIO_ZERO;
         rclk_r <= `CDIO_ZERO;
      end else begin
         rx_s1_r <= rx_tgl_r;
         rx_s2_r <= rx_s1_r;
         rx_s3_r <= rx_s2_r;
         emp_s1_r <= empty_r;
         emp_s2_r <= emp_s1_r;
         parallel_load_n_o <= ~load_go;
         if (load_go) begin
            tx_dat_r <= slice_data_i;
            tx_ab_r <= mark_pattern_a_i & mark_pattern_b_i;
            tx_b_r <= mark_pattern_b_i;
            req_tgl_r <= ~req_tgl_r;
            pending_r <= 1'b1;
         end else if (!emp_s2_r) begin
            pending_r <= 1'b0; // Link took the word and is shifting it
         end
         if (rx_new) begin
            rdata_r <= rx_dat_r;
            rclk_r <= rx_clk_r;
         end
      end
   end

   // Link side: strobes, counter, shift registers
   wire dstb = ~read_data_strobe_n_i;
   wire ld = req_l2_r ^ req_l3_r;
   wire [3:0] cnt_inc = (cnt_r == `CDIO_BITS_PER_BYTE) ? `CDIO_CNT_ONE : cnt_r + `CDIO_CNT_ONE;
   wire byte_done = dstb & ~ld & (cnt_inc == `CDIO_BITS_PER_BYTE);
   // Clock register load word: only three stages follow the mark levels
   wire [`CDIO_DW-1:0] clk_load = {2'b00, tx_ab_r, tx_b_r, tx_ab_r, 3'b000};

   // Load word is held steady by pending until the link has taken it
   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {req_l1_r, req_l2_r, req_l3_r} <= '0;
         dsr_r <= `CDIO_ZERO;
         csr_r <= `CDIO_ZERO;
         cnt_r <= `CDIO_BITS_PER_BYTE;
         empty_r <= 1'b1;
      end else begin
         req_l1_r <= req_tgl_r;
         req_l2_r <= req_l1_r;
         req_l3_r <= req_l2_r;
         if (ld) begin
            dsr_r <= tx_dat_r;
            csr_r <= clk_load;
            cnt_r <= '0;
            empty_r <= 1'b0;
         end else begin
            if (dstb) begin
               dsr_r <= {dsr_r[`CDIO_DW-2:0], ~serial_read_data_in_n_i};
               cnt_r <= cnt_inc;
               empty_r <= (cnt_inc == `CDIO_BITS_PER_BYTE);
            end
            if (clockbit_strobe_i) begin
               csr_r <= {csr_r[`CDIO_DW-2:0], ~serial_read_clockbit_in_n_i};
            end
         end
      end
   end

   // Byte hand-off toward the slice side, one toggle per completed byte
   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_tgl_r <= 1'b0;
         rx_dat_r <= `CDIO_ZERO;
         rx_clk_r <= `CDIO_ZERO;
      end else if (byte_done) begin
         rx_dat_r <= {dsr_r[`CDIO_DW-2:0], ~serial_read_data_in_n_i};
         rx_clk_r <= clockbit_strobe_i ? {csr_r[`CDIO_DW-2:0], ~serial_read_clockbit_in_n_i} :
                     csr_r;
         rx_tgl_r <= ~rx_tgl_r;
      end
   end

   assign serial_write_data_out_o = dsr_r[`CDIO_DW-1];
   assign data_reg_bit_a_out_o = dsr_r[0];
   assign data_reg_bit_b_out_o = dsr_r[1];

   // Checks on the slice side
   a_kbus_mask: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !const_force_sel_i |=> const_bus_o == ~$past(microword_mask_field_i))
      else $error("constant bus not inverted mask");
   a_kbus_const: assert property (@(posedge clock_i) disable iff (!nrst_i)
      const_force_sel_i |=> const_bus_o == ($past(const_polarity_sel_i) ? 8'h00 : 8'hFF))
      else $error("constant bus uniform value wrong");
   a_ibus_gate: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !const_force_sel_i |=> ibus_o == 8'h00)
      else $error("input bus driven without constant select");
   a_ibus_data: assert property (@(posedge clock_i) disable iff (!nrst_i)
      const_force_sel_i && microword_mask_field_i[7:3] == 5'h10 |=> ibus_o == $past(rdata_r))
      else $error("data register not on input bus");
   a_ibus_stat: assert property (@(posedge clock_i) disable iff (!nrst_i)
      const_force_sel_i && microword_mask_field_i[7:3] == 5'h1D
      |=> ibus_o == {$past(stat_s), 4'h0})
      else $error("status lines not on input bits 4 to 7");
   a_branch_flag: assert property (@(posedge clock_i) disable iff (!nrst_i)
      branch_addr_ctl_lsb_o != sequencer_flag_input_o
      && slice_carry_in_o[0] == sequencer_flag_output_i)
      else $error("branch bit not inverse of flag line");
   a_addr_enable: assert property (@(posedge clock_i) disable iff (!nrst_i)
      address_output_enable_o == sys_addr_oe_o && data_output_enable_o)
      else $error("slice output enables inconsistent");
   a_opcode_unit: assert property (@(posedge clock_i) disable iff (!nrst_i)
      opcode_latch_pulse_i |=> unit_select_hi_o == ~$past(slice_data_i[5])
      && seq_instr_sel_o == ~$past(slice_data_i[2:0]))
      else $error("opcode latch not inverted capture");
   a_hi_drive: assert property (@(posedge clock_i) disable iff (!nrst_i)
      sys_data_hi_oe_o |-> $past(granted_s) && $past(memory_write_i) && $past(wide_mode_o))
      else $error("high byte driven without all three conditions");
   a_lane_pick: assert property (@(posedge clock_i) disable iff (!nrst_i)
      byte_lane_level_i && !in_cap |=> mem_data_o == in_lo_r)
      else $error("low byte latch not chosen");
   a_load_empty: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !parallel_load_n_o |-> $past(emp_s2_r) && $past(write_gate_level_i))
      else $error("load without empty and write gate");
   // Checks on the link side
   a_tx_shift: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
      dstb && !ld |=> serial_write_data_out_o == $past(dsr_r[6]))
      else $error("serial out not from last stage");
   a_clk_pattern: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
      ld |=> csr_r[2:0] == 3'b000 && csr_r[7:6] == 2'b00)
      else $error("clock load zero stages not zero");

endmodule
`default_nettype wire

// ---- rtl/cdio_params.svh ----
`ifndef CDIO_PARAMS_SVH
`define CDIO_PARAMS_SVH

// Datapath widths
`define CDIO_DW 8
`define CDIO_FW 7
`define CDIO_SLICE_W 4
`define CDIO_SLICES 2
`define CDIO_OP_W 6

// Mask field M7..M3 patterns that pick an input-bus source
`define CDIO_PAT_DATA 5'h10
`define CDIO_PAT_CLK 5'h12
`define CDIO_PAT_ERR 5'h1A
`define CDIO_PAT_STAT 5'h1D

// Uniform constant bus values
`define CDIO_ONES 8'hFF
`define CDIO_ZERO 8'h00
`define CDIO_NIB_ZERO 4'h0

// Serial byte framing
`define CDIO_BITS_PER_BYTE 4'h8
`define CDIO_CNT_ONE 4'h1

// Opcode latch field positions
`define CDIO_OP_WIDE 3
`define CDIO_OP_USLO 4
`define CDIO_OP_USHI 5

`endif

// ---- rtl/cdio_pkg.sv ----
`default_nettype none
package cdio_pkg;
   // Input-bus source, Gray ordered
   typedef enum logic [2:0] {
      CDIO_SRC_NONE = 3'h0,
      CDIO_SRC_DATA = 3'h1,
      CDIO_SRC_CLK = 3'h3,
      CDIO_SRC_ERR = 3'h2,
      CDIO_SRC_STAT = 3'h6
   } cdio_isrc_t;
endpackage
`default_nettype wire

// ---- sim/cdio_iface_model.sv ----
`default_nettype none
// Far-side serial source and sink on the link clock
module cdio_iface_model (
   // Link clock
   input wire logic link_clk_i,
   // Serial read pins toward the channel
   output logic sdata_n_o,
   output logic dstb_n_o,
   output logic cbit_n_o,
   output logic cstb_o,
   // Serial write data back
   input wire logic wdata_i
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle: strobes inactive, data lines parked high
   initial begin
      sdata_n_o = 1'h1;
      dstb_n_o = 1'h1;
      cbit_n_o = 1'h1;
      cstb_o = 1'h0;
   end

   // One byte, oldest bit first, with a quiet link cycle between strobes
   task automatic xfer(input logic [7:0] d, input logic [7:0] c, output logic [7:0] w);
      for (int i = 7; i >= 0; i--) begin
         @(posedge link_clk_i);
         #1;
         w[i] = wdata_i;
         sdata_n_o = ~d[i];
         cbit_n_o = ~c[i];
         dstb_n_o = 1'h0;
         cstb_o = 1'h1;
         @(posedge link_clk_i);
         #1;
         dstb_n_o = 1'h1;
         cstb_o = 1'h0;
         // Released lines flip so a stale bit is never read as good
         sdata_n_o = d[i];
         cbit_n_o = c[i];
      end
   endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   // Counters and stimulus, every input starts at a known value
   int mismatches = 0;
   int cmp_count = 0;
   logic clock_i = 1'h0, link_clk_i = 1'h0, nrst_i = 1'h0;
   logic [6:0] slice_function_field_i = 7'h00;
   logic [7:0] microword_mask_field_i = 8'h00, slice_addr_i = 8'h00, slice_data_i = 8'h00;
   logic const_force_sel_i = 1'h0, const_polarity_sel_i = 1'h0, write_gate_level_i = 1'h0;
   logic mark_pattern_a_i = 1'h0, mark_pattern_b_i = 1'h0, opcode_latch_pulse_i = 1'h0;
   logic addr_latch_pulse_i = 1'h0, low_byte_out_strobe_i = 1'h0;
   logic high_byte_out_strobe_i = 1'h0, bus_input_strobe_i = 1'h0, byte_lane_level_i = 1'h0;
   logic memory_write_i = 1'h0, result_read_i = 1'h0, sequencer_flag_output_i = 1'h0;
   logic [1:0] slice_carry_out_i = 2'h0, slice_shift_out_i = 2'h0;
   logic bus_granted_i = 1'h0, memory_data_strobe_i = 1'h0, overrun_error_i = 1'h0;
   logic write_protect_flag_i = 1'h0, write_fault_flag_i = 1'h0;
   logic selected_drive_not_ready_i = 1'h0, drive_ready_a_i = 1'h0, drive_ready_b_i = 1'h0;
   logic stop_flag_i = 1'h0, track_zero_i = 1'h0;
   logic [15:0] sys_data_i = 16'h0000;
   wire serial_read_data_in_n_i, read_data_strobe_n_i;
   wire serial_read_clockbit_in_n_i, clockbit_strobe_i;
   logic [6:0] slice_function_field_o;
   logic [7:0] const_bus_o, ibus_o, mem_data_o, sys_addr_hi_o, sys_addr_lo_o;
   logic [7:0] sys_data_lo_o, sys_data_hi_o, wr_byte;
   logic address_output_enable_o, data_output_enable_o;
   logic sequencer_flag_input_o, branch_addr_ctl_lsb_o;
   logic [1:0] slice_carry_in_o, slice_shift_in_o;
   logic [2:0] seq_instr_sel_o;
   logic wide_mode_o, unit_select_lo_o, unit_select_hi_o, sys_addr_oe_o, sys_data_lo_oe_o;
   logic sys_data_hi_oe_o, parallel_load_n_o, serial_write_data_out_o;
   logic data_reg_bit_a_out_o, data_reg_bit_b_out_o;

   cdio_datapath #(.SLICES(2)) u_cdio_datapath (.*);

   cdio_iface_model u_cdio_iface_model (
      .link_clk_i(link_clk_i),
      .sdata_n_o(serial_read_data_in_n_i),
      .dstb_n_o(read_data_strobe_n_i),
      .cbit_n_o(serial_read_clockbit_in_n_i),
      .cstb_o(clockbit_strobe_i),
      .wdata_i(serial_write_data_out_o)
   );

   // Slice clock, and a link clock on an unrelated phase
   always #5 clock_i = ~clock_i;
   initial begin
      #7;
      forever #15 link_clk_i = ~link_clk_i;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Every drive lands just after a rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic end_of_test();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic uword(input logic f, input logic p, input logic [7:0] m);
      const_force_sel_i = f;
      const_polarity_sel_i = p;
      microword_mask_field_i = m;
      cyc(1);
   endtask

   // One-cycle latch pulse, then one more edge for the answer
   task automatic pulse(input int k, input logic [7:0] d);
      slice_data_i = d;
      case (k)
         0: opcode_latch_pulse_i = 1'h1;
         1: addr_latch_pulse_i = 1'h1;
         2: low_byte_out_strobe_i = 1'h1;
         3: high_byte_out_strobe_i = 1'h1;
         default: bus_input_strobe_i = 1'h1;
      endcase
      cyc(1);
      {opcode_latch_pulse_i, addr_latch_pulse_i, low_byte_out_strobe_i} = 3'h0;
      {high_byte_out_strobe_i, bus_input_strobe_i} = 2'h0;
      cyc(1);
   endtask

   initial begin
      repeat (4) @(posedge clock_i);
      #1;
      nrst_i = 1'h1;
      slice_function_field_i = 7'h55;
      cyc(1);
      chk(slice_function_field_o, 7'h55, "function");
      chk(data_output_enable_o, 1'h1, "data oe");
      uword(1'h0, 1'h0, 8'h5A);
      chk(const_bus_o, 8'hA5, "const mask");
      uword(1'h1, 1'h0, 8'h5A);
      chk(const_bus_o, 8'hFF, "const ones");
      chk(ibus_o, 8'h00, "no match");
      uword(1'h1, 1'h1, 8'h5A);
      chk(const_bus_o, 8'h00, "const zeros");
      // Flag pins pass a synchroniser, so let them settle first
      {overrun_error_i, write_protect_flag_i} = 2'h1;
      {write_fault_flag_i, selected_drive_not_ready_i} = 2'h1;
      {drive_ready_a_i, drive_ready_b_i, stop_flag_i, track_zero_i} = 4'h3;
      cyc(4);
      uword(1'h1, 1'h0, {5'h1A, 3'h7});
      chk(ibus_o, 8'hA0, "error lines");
      uword(1'h1, 1'h0, {5'h1D, 3'h0});
      chk(ibus_o, 8'hC0, "status lines");
      uword(1'h0, 1'h0, {5'h1D, 3'h0});
      chk(ibus_o, 8'h00, "no force");
      u_cdio_iface_model.xfer(8'hA5, 8'h3C, wr_byte);
      cyc(10);
      uword(1'h1, 1'h0, {5'h10, 3'h0});
      chk(ibus_o, 8'hA5, "read data");
      uword(1'h1, 1'h0, {5'h12, 3'h0});
      chk(ibus_o, 8'h3C, "read clock");
      chk({data_reg_bit_b_out_o, data_reg_bit_a_out_o}, 2'h1, "low stages");
      chk(parallel_load_n_o, 1'h1, "no load gate low");
      slice_data_i = 8'h96;
      mark_pattern_a_i = 1'h1;
      write_gate_level_i = 1'h1;
      for (int i = 0; i < 50 && parallel_load_n_o !== 1'h0; i++) begin
         cyc(1);
      end
      chk(parallel_load_n_o, 1'h0, "load");
      if (parallel_load_n_o !== 1'h0) begin
         end_of_test();
      end
      write_gate_level_i = 1'h0;
      cyc(1);
      chk(parallel_load_n_o, 1'h1, "load one cycle");
      cyc(30);
      chk({data_reg_bit_b_out_o, data_reg_bit_a_out_o}, 2'h2, "loaded stages");
      u_cdio_iface_model.xfer(8'h00, 8'h00, wr_byte);
      chk(wr_byte, 8'h96, "serial write");
      // Output latches with bus grant and memory write
      bus_granted_i = 1'h1;
      memory_write_i = 1'h1;
      slice_addr_i = 8'h3C;
      pulse(0, 8'h24);
      chk({seq_instr_sel_o, wide_mode_o, unit_select_lo_o, unit_select_hi_o}, 6'h1E, "op");
      pulse(1, 8'hC3);
      pulse(2, 8'h5A);
      pulse(3, 8'hE1);
      cyc(4);
      chk(sys_addr_lo_o, 8'hC3, "addr lo");
      chk(sys_addr_hi_o, 8'h3C, "addr hi");
      chk({address_output_enable_o, sys_addr_oe_o}, 2'h3, "addr oe");
      chk({sys_data_lo_o, sys_data_hi_o}, 16'h5AE1, "data bytes");
      chk({sys_data_lo_oe_o, sys_data_hi_oe_o}, 2'h3, "data oe");
      pulse(0, 8'h2C);
      cyc(1);
      chk(sys_data_hi_oe_o, 1'h0, "narrow mode");
      bus_granted_i = 1'h0;
      memory_write_i = 1'h0;
      result_read_i = 1'h1;
      cyc(5);
      chk({address_output_enable_o, sys_addr_oe_o, sys_data_lo_oe_o}, 3'h1, "oe off");
      result_read_i = 1'h0;
      cyc(2);
      chk(sys_data_lo_oe_o, 1'h0, "lo oe off");
      // Input latches and byte lane choice
      sys_data_i = 16'hB44D;
      byte_lane_level_i = 1'h1;
      cyc(3);
      pulse(4, 8'h00);
      cyc(1);
      chk(mem_data_o, 8'h4D, "lane low");
      byte_lane_level_i = 1'h0;
      sys_data_i = 16'h1E7F;
      cyc(3);
      chk(mem_data_o, 8'hB4, "lane high");
      memory_data_strobe_i = 1'h1;
      cyc(8);
      chk(mem_data_o, 8'h1E, "memory strobe");
      memory_data_strobe_i = 1'h0;
      // Carry and shift chain is combinational
      {slice_carry_out_i, slice_shift_out_i, sequencer_flag_output_i} = 5'h13;
      #1;
      chk({slice_carry_in_o, slice_shift_in_o, sequencer_flag_input_o,
         branch_addr_ctl_lsb_o}, 6'h1A, "chain a");
      {slice_carry_out_i, slice_shift_out_i, sequencer_flag_output_i} = 5'h0C;
      #1;
      chk({slice_carry_in_o, slice_shift_in_o, sequencer_flag_input_o,
         branch_addr_ctl_lsb_o}, 6'h25, "chain b");
      end_of_test();
   end
endmodule
`default_nettype wire
